// *** core/sadc_defines.vh ***
`ifndef SADC_DEFINES_VH
`define SADC_DEFINES_VH
// ==========================================
// timing
`define SADC_CLK_NS 50
`define SADC_CONV_NS 9000
`define SADC_CONV_CYC (`SADC_CONV_NS / `SADC_CLK_NS)
`define SADC_ACQ_NS 1500
`define SADC_ACQ_CYC ((`SADC_ACQ_NS + `SADC_CLK_NS - 1) / `SADC_CLK_NS)
`define SADC_CNT_W 9
// last count of the conversion window, conversion cycles minus one
`define SADC_CONV_LAST 9'h0b3
// one sar step every sixteen cycles of the window
`define SADC_STEP_BITS 4
// ==========================================
// result layout
`define SADC_RES_W 10
`define SADC_SUB_BITS 2
`define SADC_SHIFT_W 13
// ==========================================
// power-down input levels
`define SADC_PD_LOW 2'h0
`define SADC_PD_FLOAT 2'h1
`define SADC_PD_HIGH 2'h2
// ==========================================
// reset values
// sampled select and clock reset to their idle levels
`define SADC_RST_SELECT 1'h1
`define SADC_RST_SCLK 1'h0
`define SADC_RST_DOUT 1'h0
`define SADC_RST_OE 1'h0
`define SADC_RST_TRACKING 1'h1
`define SADC_RST_BUSY 1'h0
`define SADC_RST_SHUTDOWN 1'h0
`define SADC_RST_INT_REF 1'h0
`endif

// *** core/sadc_successive_approx_logic.v ***
`timescale 1ns/1ns
`include "sadc_defines.vh"
module sadc_successive_approx_logic (
	// clock and reset
	input wire i_clock,
	input wire i_rstn,
	// control
	input wire i_start,
	input wire i_step,
	input wire [`SADC_RES_W-1:0] i_held_sample,
	// result
	output reg [`SADC_RES_W-1:0] o_result
);
	// ==========================================
	// bitwise search
	reg [`SADC_RES_W-1:0] trial_q;
	reg [`SADC_RES_W-1:0] bit_q;
	always @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			trial_q <= 10'h000;
			bit_q <= 10'h000;
			o_result <= 10'h000;
		end else if (i_start) begin
			trial_q <= 10'h200;
			bit_q <= 10'h200;
		end else if (i_step && bit_q != 10'h000) begin
			if (trial_q > i_held_sample) begin
				trial_q <= (trial_q & ~bit_q) | (bit_q >> 1);
			end else begin
				trial_q <= trial_q | (bit_q >> 1);
			end
			bit_q <= bit_q >> 1;
			if (bit_q == 10'h001) begin
				o_result <= (trial_q > i_held_sample) ? (trial_q & ~bit_q) : trial_q;
			end
		end
	end
endmodule // sadc_successive_approx_logic

// *** core/sadc_top.v ***
`timescale 1ns/1ns
`include "sadc_defines.vh"
module sadc_top (
	// clock and reset
	input wire i_clock,
	input wire i_rstn,
	// serial link
	input wire i_select_n,
	input wire i_sclk,
	output reg o_dout,
	output reg o_dout_oe,
	// analog stand-in and power-down
	input wire [`SADC_RES_W-1:0] i_analog_sample_input,
	input wire [1:0] i_power_down_tri_level,
	output reg o_tracking,
	output reg o_busy,
	output reg o_shutdown,
	output reg o_int_ref_en
);
	// ==========================================
	// states
	// one-hot codes; anything else falls back to idle
	localparam [2:0] ST_IDLE = 3'h1;
	localparam [2:0] ST_CONV = 3'h2;
	localparam [2:0] ST_READ = 3'h4;
	// ==========================================
	// decoders
	// a line fell between its last registered sample and its present level
	function edge_fell;
		input prev_level;
		input now_level;
		edge_fell = prev_level & ~now_level;
	endfunction
	// only a driven low shuts down; floating and the spare code stay awake
	function pd_is_shutdown;
		input [1:0] level;
		pd_is_shutdown = (level == `SADC_PD_LOW);
	endfunction
	// only a driven high runs the internal reference
	function pd_uses_int_ref;
		input [1:0] level;
		pd_uses_int_ref = (level == `SADC_PD_HIGH);
	endfunction
	// ==========================================
	// storage
	reg [2:0] state_q;
	reg [2:0] state_d;
	reg sel_q;
	reg sclk_q;
	reg [`SADC_CNT_W-1:0] cnt_q;
	reg [`SADC_CNT_W-1:0] cnt_d;
	reg [`SADC_RES_W-1:0] held_q;
	reg [`SADC_RES_W-1:0] held_d;
	reg [`SADC_SHIFT_W-1:0] shift_q;
	wire [`SADC_SHIFT_W-1:0] shift_d;
	reg shift_load;
	reg shift_adv;
	reg dout_d;
	reg oe_d;
	reg tracking_d;
	reg busy_d;
	// ==========================================
	// strobes
	wire [`SADC_RES_W-1:0] result;
	wire [`SADC_SHIFT_W-1:0] shift_load_val;
	wire sel_fall;
	wire sclk_fall;
	wire shutdown;
	wire int_ref;
	wire conv_last;
	wire sar_step;
	assign sel_fall = edge_fell(sel_q, i_select_n);
	// clock falls only count in the read state, so one seen during a
	// conversion is dropped rather than shifting data early
	assign sclk_fall = edge_fell(sclk_q, i_sclk);
	assign shutdown = pd_is_shutdown(i_power_down_tri_level);
	assign int_ref = pd_uses_int_ref(i_power_down_tri_level);
	assign conv_last = (cnt_q == `SADC_CONV_LAST);
	// sar steps spread over the window; the ten steps end well before it
	// closes, so the result is settled when the end bit rises
	assign sar_step = (state_q == ST_CONV) &&
		(cnt_q[`SADC_STEP_BITS-1:0] == {`SADC_STEP_BITS{1'h0}});
	// ==========================================
	// successive approximation
	sadc_successive_approx_logic u_sar (
		.i_clock(i_clock),
		.i_rstn(i_rstn),
		.i_start(sel_fall),
		.i_step(sar_step),
		.i_held_sample(held_q),
		.o_result(result)
	);
	// ==========================================
	// result shifter
	// the result sits under the end bit; the low slots are the two sub-bits
	// and one spare, and every shift pulls in a zero so late clocks read low
	assign shift_load_val = {result, {(`SADC_SHIFT_W - `SADC_RES_W){1'h0}}};
	genvar k;
	generate
		for (k = 0; k < `SADC_SHIFT_W; k = k + 1) begin : g_shift
			if (k == 0) begin : g_first
				assign shift_d[k] = shift_load ? shift_load_val[k] :
					(shift_adv ? 1'h0 : shift_q[k]);
			end else begin : g_next
				assign shift_d[k] = shift_load ? shift_load_val[k] :
					(shift_adv ? shift_q[k-1] : shift_q[k]);
			end
		end
	endgenerate
	// ==========================================
	// next state
	always @* begin
		state_d = state_q;
		cnt_d = cnt_q;
		held_d = held_q;
		shift_load = 1'h0;
		shift_adv = 1'h0;
		dout_d = o_dout;
		oe_d = o_dout_oe;
		tracking_d = o_tracking;
		busy_d = o_busy;
		case (state_q)
			ST_IDLE: begin
				// start and hold
				// a fall in shutdown is ignored and the line stays released
				if (sel_fall && !shutdown) begin
					state_d = ST_CONV;
					held_d = i_analog_sample_input;
					cnt_d = {`SADC_CNT_W{1'h0}};
					tracking_d = 1'h0;
					busy_d = 1'h1;
					dout_d = 1'h0;
					oe_d = 1'h1;
				end
			end
			ST_CONV: begin
				if (conv_last) begin
					state_d = ST_READ;
					tracking_d = 1'h1;
					busy_d = 1'h0;
					dout_d = 1'h1;
					shift_load = 1'h1;
				end else begin
					cnt_d = cnt_q + {{(`SADC_CNT_W - 1){1'h0}}, 1'h1};
				end
			end
			ST_READ: begin
				if (sclk_fall) begin
					dout_d = shift_q[`SADC_SHIFT_W-1];
					shift_adv = 1'h1;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
		// release when select high
		// raising select mid-conversion abandons it; the next fall starts over
		if (i_select_n) begin
			state_d = ST_IDLE;
			oe_d = 1'h0;
			dout_d = 1'h0;
			busy_d = 1'h0;
			tracking_d = 1'h1;
		end
	end
	// ==========================================
	// registers
	// select and clock samples reset to their idle levels,
	// so leaving reset with both lines idle never looks like an edge
	always @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			state_q <= ST_IDLE;
			sel_q <= `SADC_RST_SELECT;
			sclk_q <= `SADC_RST_SCLK;
			cnt_q <= {`SADC_CNT_W{1'h0}};
			held_q <= {`SADC_RES_W{1'h0}};
			shift_q <= {`SADC_SHIFT_W{1'h0}};
			o_dout <= `SADC_RST_DOUT;
			o_dout_oe <= `SADC_RST_OE;
			o_tracking <= `SADC_RST_TRACKING;
			o_busy <= `SADC_RST_BUSY;
			o_shutdown <= `SADC_RST_SHUTDOWN;
			o_int_ref_en <= `SADC_RST_INT_REF;
		end else begin
			state_q <= state_d;
			sel_q <= i_select_n;
			sclk_q <= i_sclk;
			cnt_q <= cnt_d;
			held_q <= held_d;
			shift_q <= shift_d;
			o_dout <= dout_d;
			o_dout_oe <= oe_d;
			o_tracking <= tracking_d;
			o_busy <= busy_d;
			// shutdown decode
			// registered, so it trails the pin by one cycle
			o_shutdown <= shutdown;
			o_int_ref_en <= int_ref;
		end
	end
endmodule // sadc_top

// *** sim/sadc_host_model.sv ***
`timescale 1ns/1ns
// ==
// host master
module sadc_host_model (
	input wire i_clock,
	input wire i_dout,
	output reg o_select_n = 1'b1,
	output reg o_sclk = 1'b0,
	output reg [15:0] o_word = 16'h0000,
	output reg o_done = 1'b0
);
	task automatic frame(input bit sd, input int gap);
		int i;
		repeat (30 + gap) @(posedge i_clock);
		#5 o_select_n = 1'b0;
		i = 0;
		do begin @(posedge i_clock); #5; i++; end while (!sd && i < 400 && i_dout !== 1'b1);
		o_word[15] = i_dout;
		for (i = 14; i >= 0 && !sd; i--) begin
			repeat (5) @(posedge i_clock);
			#5 o_sclk = 1'b1;
			repeat (5) @(posedge i_clock);
			#5 o_sclk = 1'b0;
			repeat (5) @(posedge i_clock);
			#5 o_word[i] = i_dout;
		end
		#0 o_select_n = 1'b1;
		o_done = !sd;
		@(posedge i_clock);
		#5 o_done = 1'b0;
	endtask
endmodule // sadc_host_model

// *** sim/sadc_top_bench.sv ***
`timescale 1ns/1ns
// ==
// bench
module sadc_top_bench;
	reg clk = 1'b0, rstn = 1'b0, tog = 1'b0;
	reg [9:0] smp = 10'h000;
	reg [1:0] pd = 2'h2;
	wire sel_n, sclk, dout, oe, done;
	wire [15:0] word;
	logic [15:0] notes[$];
	int miscompares = 0, samples_checked = 0, n;
	initial forever #25 clk = ~clk;
	always @(posedge clk) tog <= ~tog;
	sadc_top u_dut (.i_clock(clk), .i_rstn(rstn), .i_select_n(sel_n), .i_sclk(sclk),
		.o_dout(dout), .o_dout_oe(oe), .i_analog_sample_input(smp),
		.i_power_down_tri_level(pd), .o_tracking(), .o_busy(), .o_shutdown(), .o_int_ref_en());
	// a released line must not look like a held bit
	sadc_host_model u_host (.i_clock(clk), .i_dout(oe ? dout : tog), .o_select_n(sel_n),
		.o_sclk(sclk), .o_word(word), .o_done(done));
	task test_done;
		$display("checked %0d errors %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	always @(posedge done) begin
		samples_checked++;
		if (notes.size() == 0 || word !== notes.pop_front()) begin
			miscompares++;
			$display("Error %0t bad frame %h", $time, word);
		end
	end
	initial begin
		n = $urandom(82);
		repeat (20) @(posedge clk);
		#5 rstn = 1'b1;
		for (n = 0; n < 16; n++) begin
			smp = (n < 2) ? {10{n[0]}} : 10'($urandom);
			pd = 2'h1 + 2'($urandom % 3);
			notes.push_back({1'b1, smp, 5'h00});
			u_host.frame(1'b0, $urandom % 20);
		end
		// shutdown must refuse the start
		pd = 2'h0;
		u_host.frame(1'b1, 0);
		test_done;
	end
	initial begin
		#1000000;
		miscompares++;
		test_done;
	end
endmodule // sadc_top_bench

// *** sim/sadc_top_properties.sv ***
`timescale 1ns/1ns
// ==
// port checks
module sadc_top_props (
	input wire i_clock, i_rstn, i_select_n, i_sclk, o_dout, o_dout_oe,
	input wire [1:0] i_power_down_tri_level,
	input wire o_tracking, o_busy, o_shutdown, o_int_ref_en
);
	wire [1:0] pd = i_power_down_tri_level;
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rstn);
	sequence s_fall; !i_select_n && $past(i_select_n); endsequence
	sequence s_conv; ##179 o_busy ##1 !o_busy && o_dout && o_tracking; endsequence
	property p_start; s_fall ##0 !o_busy && !o_shutdown && pd != 2'h0
		|=> o_busy && o_dout_oe && !o_dout && !o_tracking; endproperty
	a_start: assert property (p_start) else $error("bad start");
	// raising select abandons a conversion legally, so it suspends this check
	property p_conv; disable iff (!i_rstn || i_select_n) $rose(o_busy) |-> s_conv;
		endproperty
	a_conv: assert property (p_conv) else $error("bad conversion");
	property p_hiz; i_select_n |=> !o_dout_oe; endproperty
	a_hiz: assert property (p_hiz) else $error("not released");
	property p_hold; o_dout_oe && !i_select_n |=> o_dout_oe; endproperty
	a_hold: assert property (p_hold) else $error("drive lost");
	// only the end bit may move while the clock is high
	property p_edge; $changed(o_dout) && o_dout_oe && $past(o_dout_oe) && !$past(o_busy)
		|-> !i_sclk; endproperty
	a_edge: assert property (p_edge) else $error("data moved off fall");
	property p_sd; s_fall ##0 o_shutdown && !o_busy |=> !o_busy; endproperty
	a_sd: assert property (p_sd) else $error("start in shutdown");
	property p_pd; 1'b1 |=> o_shutdown == ($past(pd) == 2'h0); endproperty
	a_pd: assert property (p_pd) else $error("bad shutdown");
	property p_ref; 1'b1 |=> o_int_ref_en == ($past(pd) == 2'h2); endproperty
	a_ref: assert property (p_ref) else $error("bad reference");
endmodule // sadc_top_props
bind sadc_top sadc_top_props u_props (.i_clock, .i_rstn, .i_select_n, .i_sclk, .o_dout,
	.o_dout_oe, .i_power_down_tri_level, .o_tracking, .o_busy, .o_shutdown, .o_int_ref_en);
